// ===== rtl/bit_phase_timer.sv
// Purpose: bit phase counter at 128 steps per bit with add/delete phase pull
// Assumes: tick is a one-cycle pulse at 128 times the bit rate
// Notes: restart forces phase zero for start-stop framing
`timescale 1ns/1ns
`include "tgr_params.svh"

module bit_phase_timer #(
   parameter int NORMAL_PULL_DIV = `TGR_NORMAL_PULL_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic restart,
   input wire logic transition,
   input wire logic track,
   input wire logic fast,
   output logic mid_strobe
);
   import tgr_pkg::*;

   localparam logic [6:0] HALF = 7'(`TGR_HALF_BIT);

   logic [6:0] phase;
   logic [6:0] next_phase;
   logic advance;
   logic next_advance;
   logic retard;
   logic next_retard;
   logic [4:0] div_cnt;
   logic [4:0] next_div_cnt;
   logic next_mid;
   logic take;

   always_comb begin
      next_phase = phase;
      next_advance = advance;
      next_retard = retard;
      next_div_cnt = div_cnt;
      next_mid = 1'b0;
      // normal setting only lets one transition in NORMAL_PULL_DIV pull the clock
      take = fast || (div_cnt == 5'(NORMAL_PULL_DIV - 1));
      if (restart) begin
         next_phase = 7'h00;
         next_advance = 1'b0;
         next_retard = 1'b0;
         next_div_cnt = 5'h00;
      end else begin
         if (tick) begin
            if (retard) begin
               next_retard = 1'b0;
            end else if (advance) begin
               next_phase = phase + 7'h02;
               next_advance = 1'b0;
            end else begin
               next_phase = phase + 7'h01;
            end
            next_mid = (phase < HALF) && (next_phase >= HALF);
         end
         if (track && transition && phase != 7'h00) begin
            next_div_cnt = take ? 5'h00 : div_cnt + 5'h01;
            if (take) begin
               // a late edge means the clock runs ahead: hold it back one step
               next_retard = (phase < HALF);
               next_advance = (phase >= HALF);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= 7'h00;
         advance <= 1'b0;
         retard <= 1'b0;
         div_cnt <= 5'h00;
         mid_strobe <= 1'b0;
      end else begin
         phase <= next_phase;
         advance <= next_advance;
         retard <= next_retard;
         div_cnt <= next_div_cnt;
         mid_strobe <= next_mid;
      end
   end

endmodule : bit_phase_timer

// ===== rtl/telegraph_regen.sv
// Purpose: mode selection, configuration and retiming of a telegraph regenerative repeater
// Assumes: LINE_IN high means Mark; all inputs synchronous to REF_CLK
// Notes: configuration sits in an APB control register; zero wait states
//
// How it works
// - control field picks 5 to 8 units per start-stop character
// - control bit enables mark hold, used only in start-stop regeneration
// - with mark hold the stop interval is sent as Mark, input ignored
// - high immunity doubles long-mark evidence needed to leave synchronous mode
// - speed field offers 60 wpm, 100 wpm, 75 and 150 baud
// - external position takes bit timing from the external timing input
// - external timing runs at 256 times bit rate; time base is 128 times
// - automatic mode chooses start-stop or synchronous from the traffic seen
// - manual selector forces start-stop or synchronous only when not automatic
// - phase setting applies only in synchronous mode, on mark-to-space edges
// - normal setting pulls on one edge in sixteen, about 1000 edges
// - fast setting pulls on every edge, within 64 edges
// - each pulling edge adds or deletes one of 128 time-base steps
// - mark indicator is lit whenever the input is Mark
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "tgr_params.svh"

module telegraph_regen #(
   parameter int LONG_MARK_CYC = `TGR_LONG_MARK_MS * (`TGR_CLK_HZ / 1000),
   parameter int MISS_LIMIT = `TGR_MISS_LIMIT
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LINE_IN,
   input wire logic EXTERNAL_TIMING,
   output logic REGEN_OUT,
   output logic MARK_LAMP,
   output logic SYNC_MODE
);
   import tgr_pkg::*;

   localparam logic [63:0] INC_60 = 64'(`TGR_CB_60WPM) * 64'(`TGR_NCO_SCALE) / 64'(`TGR_CB_CLK);
   localparam logic [63:0] INC_100 = 64'(`TGR_CB_100WPM) * 64'(`TGR_NCO_SCALE) / 64'(`TGR_CB_CLK);
   localparam logic [63:0] INC_75 = 64'(`TGR_CB_75) * 64'(`TGR_NCO_SCALE) / 64'(`TGR_CB_CLK);
   localparam logic [63:0] INC_150 = 64'(`TGR_CB_150) * 64'(`TGR_NCO_SCALE) / 64'(`TGR_CB_CLK);
   localparam int LM_W = $clog2(2 * LONG_MARK_CYC + 1);
   localparam logic [LM_W-1:0] LM_LO = LM_W'(LONG_MARK_CYC);
   localparam logic [LM_W-1:0] LM_HI = LM_W'(2 * LONG_MARK_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // register bus

   logic [`TGR_CTRL_WIDTH-1:0] ctrl;
   logic [`TGR_CTRL_WIDTH-1:0] next_ctrl;
   logic [31:0] next_prdata;
   logic hit_ctrl;
   logic hit_status;
   logic [`TGR_STAT_WIDTH-1:0] status;

   assign hit_ctrl = (PADDR == `TGR_CTRL_OFS);
   assign hit_status = (PADDR == `TGR_STATUS_OFS);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !(hit_ctrl || hit_status);

   always_comb begin
      next_ctrl = ctrl;
      next_prdata = PRDATA;
      if (PSEL && PENABLE && PWRITE && hit_ctrl) begin
         next_ctrl = PWDATA[`TGR_CTRL_WIDTH-1:0];
      end
      // read data is captured in the setup cycle so it leaves a flip-flop
      if (PSEL && !PENABLE) begin
         if (hit_ctrl) begin
            next_prdata = {{(32 - `TGR_CTRL_WIDTH) {1'b0}}, ctrl};
         end else if (hit_status) begin
            next_prdata = {{(32 - `TGR_STAT_WIDTH) {1'b0}}, status};
         end else begin
            next_prdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ctrl <= `TGR_CTRL_RST;
         PRDATA <= 32'h00000000;
      end else begin
         ctrl <= next_ctrl;
         PRDATA <= next_prdata;
      end
   end

   // configuration fields
   logic [1:0] len_code;
   logic mark_hold;
   logic high_immunity;
   line_speed_selector_t line_speed_selector;
   logic mode_auto;
   logic manual_sync;
   logic phase_fast;
   logic [3:0] units;

   assign len_code = ctrl[`TGR_CTRL_LEN_MSB:`TGR_CTRL_LEN_LSB];
   assign mark_hold = ctrl[`TGR_CTRL_MARK_HOLD];
   assign high_immunity = ctrl[`TGR_CTRL_HIGH_IMMUNITY];
   assign line_speed_selector = line_speed_selector_t'(ctrl[`TGR_CTRL_SPEED_MSB:`TGR_CTRL_SPEED_LSB]);
   assign mode_auto = ctrl[`TGR_CTRL_MODE_AUTO];
   assign manual_sync = ctrl[`TGR_CTRL_MANUAL_SYNC];
   assign phase_fast = ctrl[`TGR_CTRL_PHASE_FAST];
   assign units = 4'(`TGR_MIN_UNITS) + {2'b00, len_code};

   ////////////////////////////////////////////////////////////////////////////
   // time base at 128 times the bit rate

   logic [31:0] nco_inc;
   logic [31:0] nco;
   logic [31:0] next_nco;
   logic nco_carry;
   logic timing_prev;
   logic next_timing_prev;
   logic timing_half;
   logic next_timing_half;
   logic timing_rise;
   logic tick;

   always_comb begin
      unique case (line_speed_selector)
         SPEED_60WPM: nco_inc = INC_60[31:0];
         SPEED_100WPM: nco_inc = INC_100[31:0];
         SPEED_75: nco_inc = INC_75[31:0];
         SPEED_150: nco_inc = INC_150[31:0];
         EXTERNAL_TIMING_POSITION: nco_inc = 32'h00000000;
         default: nco_inc = INC_60[31:0];
      endcase
   end

   always_comb begin
      {nco_carry, next_nco} = {1'b0, nco} + {1'b0, nco_inc};
      next_timing_prev = EXTERNAL_TIMING;
      timing_rise = EXTERNAL_TIMING && !timing_prev;
      // halve the external 256x rate down to the 128x time base
      next_timing_half = timing_rise ? !timing_half : timing_half;
   end

   assign tick = (line_speed_selector == EXTERNAL_TIMING_POSITION) ? (timing_rise && timing_half)
                                                                   : nco_carry;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         nco <= 32'h00000000;
         timing_prev <= 1'b0;
         timing_half <= 1'b0;
      end else begin
         nco <= next_nco;
         timing_prev <= next_timing_prev;
         timing_half <= next_timing_half;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line edge detect and bit timer

   logic line_prev;
   logic next_line_prev;
   logic ms_edge;
   logic sync_eff;
   logic ss_restart;
   logic mid;

   assign next_line_prev = LINE_IN;
   assign ms_edge = line_prev && !LINE_IN;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         line_prev <= 1'b1;
      end else begin
         line_prev <= next_line_prev;
      end
   end

   bit_phase_timer #(
      .NORMAL_PULL_DIV(`TGR_NORMAL_PULL_DIV)
   ) u_timer (
      .clk(REF_CLK),
      .rst(RST),
      .tick(tick),
      .restart(ss_restart),
      .transition(ms_edge),
      .track(sync_eff),
      .fast(phase_fast),
      .mid_strobe(mid)
   );

   ////////////////////////////////////////////////////////////////////////////
   // start-stop framing and output retiming

   ss_state_t ss_state;
   ss_state_t next_ss_state;
   logic [3:0] unit_cnt;
   logic [3:0] next_unit_cnt;
   logic regen;
   logic next_regen;
   logic stop_good;
   logic stop_miss;

   assign ss_restart = !sync_eff && (ss_state == SS_IDLE) && ms_edge;

   always_comb begin
      next_ss_state = ss_state;
      next_unit_cnt = unit_cnt;
      next_regen = regen;
      stop_good = 1'b0;
      stop_miss = 1'b0;
      if (sync_eff) begin
         next_ss_state = SS_IDLE;
         if (mid) begin
            next_regen = LINE_IN;
         end
      end else begin
         unique case (ss_state)
            SS_IDLE: begin
               // the stop element stands a full unit before the line is followed again
               if (mid) begin
                  next_regen = LINE_IN;
               end
               if (ms_edge) begin
                  next_ss_state = SS_START;
               end
            end
            SS_START: begin
               // a start element that is Mark again at mid-bit was noise
               if (mid) begin
                  if (LINE_IN) begin
                     next_ss_state = SS_IDLE;
                  end else begin
                     next_regen = 1'b0;
                     next_unit_cnt = 4'h2;
                     next_ss_state = SS_DATA;
                  end
               end
            end
            SS_DATA: begin
               if (mid) begin
                  next_regen = LINE_IN;
                  next_unit_cnt = unit_cnt + 4'h1;
                  if (unit_cnt == units + 4'h1) begin
                     next_ss_state = SS_STOP;
                  end
               end
            end
            SS_STOP: begin
               // the last data element keeps its full unit; mark hold acts from the stop mid-bit on
               if (mid) begin
                  next_regen = mark_hold ? 1'b1 : LINE_IN;
                  stop_good = LINE_IN;
                  stop_miss = !LINE_IN;
                  next_ss_state = SS_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ss_state <= SS_IDLE;
         unit_cnt <= 4'h0;
         regen <= 1'b1;
      end else begin
         ss_state <= next_ss_state;
         unit_cnt <= next_unit_cnt;
         regen <= next_regen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // automatic mode decision

   logic auto_sync;
   logic next_auto_sync;
   logic [LM_W-1:0] mark_cnt;
   logic [LM_W-1:0] next_mark_cnt;
   logic [LM_W-1:0] mark_limit;
   logic [3:0] miss_cnt;
   logic [3:0] next_miss_cnt;

   // trading switch latency for noise immunity: a longer mark is demanded
   assign mark_limit = high_immunity ? LM_HI : LM_LO;

   always_comb begin
      next_auto_sync = auto_sync;
      next_mark_cnt = mark_cnt;
      next_miss_cnt = miss_cnt;
      if (!LINE_IN) begin
         next_mark_cnt = '0;
      end else if (mark_cnt != mark_limit) begin
         next_mark_cnt = mark_cnt + LM_W'(1);
      end
      if (auto_sync) begin
         next_miss_cnt = 4'h0;
         if (LINE_IN && mark_cnt == mark_limit) begin
            next_auto_sync = 1'b0;
         end
      end else begin
         if (stop_good) begin
            next_miss_cnt = 4'h0;
         end else if (stop_miss) begin
            next_miss_cnt = miss_cnt + 4'h1;
            if (miss_cnt == 4'(MISS_LIMIT - 1)) begin
               next_auto_sync = 1'b1;
               next_miss_cnt = 4'h0;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         auto_sync <= 1'b0;
         mark_cnt <= '0;
         miss_cnt <= 4'h0;
      end else begin
         auto_sync <= next_auto_sync;
         mark_cnt <= next_mark_cnt;
         miss_cnt <= next_miss_cnt;
      end
   end

   assign sync_eff = mode_auto ? auto_sync : manual_sync;

   ////////////////////////////////////////////////////////////////////////////
   // outputs and status

   logic lamp;
   logic next_lamp;
   logic sync_q;
   logic next_sync_q;

   assign next_lamp = LINE_IN;
   assign next_sync_q = sync_eff;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         lamp <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         lamp <= next_lamp;
         sync_q <= next_sync_q;
      end
   end

   assign REGEN_OUT = regen;
   assign MARK_LAMP = lamp;
   assign SYNC_MODE = sync_q;
   assign status = {regen, lamp, sync_q};

endmodule : telegraph_regen

// ===== rtl/tgr_params.svh
// Purpose: constants for the telegraph regenerator mode and configuration block
// Assumes: 50 MHz reference clock, APB register access
// Notes: offsets are byte addresses, one 32-bit word per register
`ifndef TGR_PARAMS_SVH
`define TGR_PARAMS_SVH

`define TGR_CLK_HZ 50000000
// register byte offsets
`define TGR_CTRL_OFS 8'h00
`define TGR_STATUS_OFS 8'h04
// control fields
`define TGR_CTRL_LEN_LSB 0
`define TGR_CTRL_LEN_MSB 1
`define TGR_CTRL_MARK_HOLD 2
`define TGR_CTRL_HIGH_IMMUNITY 3
`define TGR_CTRL_SPEED_LSB 4
`define TGR_CTRL_SPEED_MSB 6
`define TGR_CTRL_MODE_AUTO 7
`define TGR_CTRL_MANUAL_SYNC 8
`define TGR_CTRL_PHASE_FAST 9
`define TGR_CTRL_WIDTH 10
// 8-unit code, no mark hold, low immunity, 60 wpm, automatic, start-stop, normal phase
`define TGR_CTRL_RST 10'h083
// status fields
`define TGR_STAT_SYNC 0
`define TGR_STAT_MARK 1
`define TGR_STAT_OUT 2
`define TGR_STAT_WIDTH 3
// shortest character length in units
`define TGR_MIN_UNITS 5
// nominal line rates in hundredths of a baud
`define TGR_CB_60WPM 4545
`define TGR_CB_100WPM 7420
`define TGR_CB_75 7500
`define TGR_CB_150 15000
// 128 x 2^32 and 100 x clock rate, for the time-base accumulator
`define TGR_NCO_SCALE 64'h0000008000000000
`define TGR_CB_CLK 64'h000000012A05F200
// time-base ticks per bit and half bit
`define TGR_TICKS_PER_BIT 128
`define TGR_HALF_BIT 64
// normal phase setting corrects on one transition in this many
`define TGR_NORMAL_PULL_DIV 16
// long mark that means start-stop traffic, in ms
`define TGR_LONG_MARK_MS 1000
// consecutive frames with a missing stop mark that mean synchronous traffic
`define TGR_MISS_LIMIT 3

`endif

// ===== rtl/tgr_pkg.sv
// Purpose: types shared by the regenerator files
// Assumes: nothing beyond the parameter header
// Notes: codes are written out so the control register readback is stable
package tgr_pkg;

   typedef enum logic [2:0] {
      SPEED_60WPM = 3'b000,
      SPEED_100WPM = 3'b001,
      SPEED_75 = 3'b010,
      SPEED_150 = 3'b011,
      EXTERNAL_TIMING_POSITION = 3'b100
   } line_speed_selector_t;

   typedef enum logic [1:0] {
      SS_IDLE = 2'b00,
      SS_START = 2'b01,
      SS_DATA = 2'b10,
      SS_STOP = 2'b11
   } ss_state_t;

endpackage : tgr_pkg

// ===== testbench/line_station.sv
// Purpose: far-end line loop equipment and external timing source
// Assumes: bit time of BIT_CYC reference cycles, a multiple of 512
// Notes: data elements go out least significant first; line rests at Mark
`timescale 1ns/1ns
module line_station #(
   parameter int BIT_CYC = 1024
) (
   input wire logic clk,
   output logic external_timing,
   output logic line
);
   int div;
   initial begin
      external_timing = 1'h0;
      line = 1'h1;
      div = 0;
   end
   // timing runs free at 256 periods per bit
   always @(posedge clk) begin
      div <= (div + 1) % (BIT_CYC / 512);
      if (div == BIT_CYC / 512 - 1) begin
         external_timing <= !external_timing;
      end
   end
   // start element, units data elements, one stop element, then back to Mark
   task automatic send_char(input int units, input logic [7:0] data, input logic stop);
      logic [9:0] fr;
      fr = {1'h1, data, 1'h0};
      for (int k = 0; k < units + 2; k++) begin
         @(posedge clk);
         line <= (k > units) ? stop : fr[k];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
      @(posedge clk);
      line <= 1'h1;
   endtask : send_char
endmodule : line_station

// ===== testbench/regen_chk.sv
// Purpose: port-level checks for the telegraph regenerator
// Assumes: zero wait-state APB; control word shadowed here from observed writes
// Notes: bound to every telegraph_regen instance
`timescale 1ns/1ns
module regen_chk #(
   parameter int LONG_MARK_CYC = 2000,
   parameter int MISS_LIMIT = 3
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic LINE_IN,
   input wire logic EXTERNAL_TIMING,
   input wire logic REGEN_OUT,
   input wire logic MARK_LAMP,
   input wire logic SYNC_MODE
);
   logic [9:0] ctrl_shadow;
   logic [9:0] next_ctrl_shadow;
   always_comb begin
      next_ctrl_shadow = ctrl_shadow;
      if (RST) begin
         next_ctrl_shadow = 10'h083;
      end else if (PSEL && PENABLE && PWRITE && PREADY && PADDR == 8'h00) begin
         next_ctrl_shadow = PWDATA[9:0];
      end
   end
   always_ff @(posedge REF_CLK) begin
      ctrl_shadow <= next_ctrl_shadow;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence rd_acc(logic [7:0] a);
      PSEL && PENABLE && !PWRITE && PADDR == a;
   endsequence
   sequence space_edge;
      LINE_IN ##1 !LINE_IN;
   endsequence
   // read data is captured at the setup edge, so compare against values one edge back
   ready_tied_a: assert property (PREADY) else $error("pready low");
   slverr_map_a: assert property (PSLVERR == (PSEL && PENABLE && PADDR != 8'h00 && PADDR != 8'h04))
      else $error("pslverr wrong");
   unmapped_read_a: assert property (rd_acc(8'h08) |-> PRDATA == 32'h0) else $error("unmapped read not zero");
   ctrl_readback_a: assert property (rd_acc(8'h00) |-> PRDATA == {22'h0, $past(ctrl_shadow)})
      else $error("control readback wrong");
   status_read_a: assert property (rd_acc(8'h04) |-> PRDATA == {29'h0, $past(REGEN_OUT), $past(MARK_LAMP),
      $past(SYNC_MODE)}) else $error("status readback wrong");
   lamp_follow_a: assert property (space_edge |-> MARK_LAMP ##1 !MARK_LAMP)
      else $error("mark lamp does not follow line");
   reset_state_a: assert property ($past(RST) |-> REGEN_OUT && !SYNC_MODE && !MARK_LAMP && PRDATA == 32'h0)
      else $error("reset state wrong");
   manual_mode_a: assert property ((!ctrl_shadow[7] && $stable(ctrl_shadow)) [*3] |->
      SYNC_MODE == ctrl_shadow[8]) else $error("manual mode not applied");
endmodule : regen_chk
bind telegraph_regen regen_chk #(.LONG_MARK_CYC(LONG_MARK_CYC), .MISS_LIMIT(MISS_LIMIT)) chk (.REF_CLK(REF_CLK),
   .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_IN(LINE_IN), .EXTERNAL_TIMING(EXTERNAL_TIMING), .REGEN_OUT(REGEN_OUT),
   .MARK_LAMP(MARK_LAMP), .SYNC_MODE(SYNC_MODE));

// ===== testbench/tb.sv
// Purpose: self-checking bench for the telegraph regenerator
// Assumes: external timing at 1024 reference cycles per bit; long mark shortened to 2000 cycles
// Notes: expected line elements come from the frame the far end was told to send
`timescale 1ns/1ns
module tb;
   localparam int BIT_CYC = 1024;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, line_in, external_timing;
   logic regen_out, mark_lamp, sync_mode;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er;
   int err_count, cmp_count, cyc;
   telegraph_regen #(.LONG_MARK_CYC(2000), .MISS_LIMIT(3)) dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .LINE_IN(line_in), .EXTERNAL_TIMING(external_timing), .REGEN_OUT(regen_out),
      .MARK_LAMP(mark_lamp), .SYNC_MODE(sync_mode));
   line_station #(.BIT_CYC(BIT_CYC)) far (.clk(ref_clk), .external_timing(external_timing), .line(line_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do @(posedge ref_clk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : xfer
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_regs();
      xfer(8'h00, 1'h0, 32'h0, rd, er);
      check("ctrl reset", 32'h083, rd);
      xfer(8'h04, 1'h0, 32'h0, rd, er);
      check("status idle", 32'h6, rd);
      xfer(8'h00, 1'h1, 32'hFFFFFFFF, rd, er);
      xfer(8'h04, 1'h1, 32'h0, rd, er);
      xfer(8'h00, 1'h0, 32'h0, rd, er);
      check("ctrl all ones", 32'h3FF, rd);
      xfer(8'h08, 1'h0, 32'h0, rd, er);
      check("unmapped read", 32'h0, rd);
      check("unmapped error", 32'h1, {31'h0, er});
      $display("test_regs done");
   endtask : test_regs
   task automatic test_manual();
      xfer(8'h00, 1'h1, 32'h1C0, rd, er);
      repeat (4) @(posedge ref_clk);
      check("selector ignored in auto", 32'h0, {31'h0, sync_mode});
      xfer(8'h00, 1'h1, 32'h140, rd, er);
      repeat (4) @(posedge ref_clk);
      check("manual sync", 32'h1, {31'h0, sync_mode});
      xfer(8'h04, 1'h0, 32'h0, rd, er);
      check("status sync bit", 32'h1, {31'h0, rd[0]});
      fork
         far.send_char(5, 8'h00, 1'h0);
         begin
            repeat (4 * BIT_CYC) @(posedge ref_clk);
            check("sync space regenerated", 32'h0, {31'h0, regen_out});
         end
      join
      repeat (2 * BIT_CYC) @(posedge ref_clk);
      check("sync mark regenerated", 32'h1, {31'h0, regen_out});
      xfer(8'h00, 1'h1, 32'h040, rd, er);
      repeat (4) @(posedge ref_clk);
      check("manual start-stop", 32'h0, {31'h0, sync_mode});
      $display("test_manual done");
   endtask : test_manual
   // output element k is judged near its middle, one bit after the input element started
   task automatic test_frame(input int units, input logic [7:0] data, input logic stop, input logic hold);
      logic [9:0] fr;
      fr = {1'h1, data, 1'h0};
      xfer(8'h00, 1'h1, 32'h0C0 | (32'(hold) << 2) | 32'(units - 5), rd, er);
      fork
         far.send_char(units, data, stop);
         for (int k = 0; k < units + 2; k++) begin
            repeat (BIT_CYC) @(posedge ref_clk);
            check("regenerated element", {31'h0, (k > units) ? (stop | hold) : fr[k]}, {31'h0, regen_out});
         end
      join
      $display("test_frame %0d units done", units);
   endtask : test_frame
   task automatic test_auto();
      xfer(8'h00, 1'h1, 32'h0C8, rd, er);
      repeat (2) far.send_char(5, 8'h15, 1'h0);
      check("start-stop below miss limit", 32'h0, {31'h0, sync_mode});
      far.send_char(5, 8'h15, 1'h0);
      check("sync after missed stops", 32'h1, {31'h0, sync_mode});
      repeat (3950) @(posedge ref_clk);
      check("sync kept under high immunity", 32'h1, {31'h0, sync_mode});
      repeat (100) @(posedge ref_clk);
      check("start-stop after long mark", 32'h0, {31'h0, sync_mode});
      $display("test_auto done");
   endtask : test_auto
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end
   // a hang is cut well beyond the roughly 60400 cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_count++;
         $display("mismatch run length expected finish seen timeout");
         complete_run();
      end
   end
   initial begin
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_count = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      test_regs();
      test_manual();
      test_frame(6, 8'h2A, 1'h0, 1'h0);
      test_frame(8, 8'h35, 1'h0, 1'h1);
      test_frame(5, 8'h0D, 1'h1, 1'h0);
      test_auto();
      complete_run();
   end
endmodule : tb
